/* File: rtl/adc_group_scan_buffer_sequencer.sv */
/*
  Converter sequencer: register port, scan/buffer sequencing, flag handling.
  Assumes a converter core that takes a one-cycle start with a channel and
  returns a one-cycle done pulse with the result some cycles later.
*/
// Behaviour
// R01: Scan keeps start set, repeats until cleared
// R02: Flag set after first full pass
// R03: Flag with enable pauses scanning
// R04: Paused scan resumes when flag cleared
// R05: Flag clears by write zero after read
// R06: Buffered result shifts chain on write
// R07: Buffer select picks one of three chains
// R08: Software sets group, two-group code, top bit zero
// R09: Low channel bits set buffer flag point
// R10: Single stops at flag, scan keeps shifting
// R11: Select-single buffered idles each pass, counts
// R12: Flag with enable raises interrupt request
// R13: Channel code appends inputs after buffered ones
// R14: Four-stage code 110 uses A, E to G
// R15: Reading final result clears flag automatically
// R16: Buffer select zero resets buffer count
// R17: New buffer sequence applies on resume
// R18: Software changes buffer select only when stopped
// R19: Trigger sets start like software does
// R20: Unavailable combinations run without buffering
`timescale 1ns/1ns
module adc_group_scan_buffer_sequencer #(
  parameter int RES_W = adc_scan_pkg::RES_W
) (
  input  wire logic                   mclk,
  input  wire logic                   reset,
  input  wire logic                   ce,
  input  adc_scan_pkg::bus_req_t      busReq,
  output logic      [31:0]            readData,
  input  wire logic                   timerTrigger,
  input  wire logic                   extTrigger,
  output logic                        convStart,
  output logic      [2:0]             convChannel,
  input  wire logic                   convDone,
  input  wire logic [RES_W-1:0]       convData,
  output logic                        conversionEndIrq
);
  import adc_scan_pkg::*;

  // ==========================================================
  // Configuration and sequencing state
  seq_state_t            state;
  seq_state_t            next_state;
  logic                  flag;
  logic                  next_flag;
  logic                  ie;
  logic                  next_ie;
  logic                  start;
  logic                  next_start;
  logic                  scan;
  logic                  next_scan;
  logic                  autoClr;
  logic                  next_autoClr;
  logic                  armed;
  logic                  next_armed;
  logic [1:0]            bufSel;
  logic [1:0]            next_bufSel;
  logic                  multi_channel_mode;
  logic                  next_grp;
  logic [2:0]            ch;
  logic [2:0]            next_ch;
  logic [1:0]            trgSel;
  logic [1:0]            next_trgSel;
  logic [2:0]            idx;
  logic [2:0]            next_idx;
  logic [2:0]            passCount;
  logic [2:0]            next_passCount;
  logic [31:0]           next_readData;
  plan_t                 plan;
  logic [7:0][RES_W-1:0] results;
  logic                  wrCsr;
  logic                  wrCr;
  logic                  rdCsr;
  logic                  rdLast;
  logic                  trigHit;
  logic                  doneAny;
  logic                  doneLast;
  logic                  passHit;

  // Plan follows the registers directly, so a new buffer code takes effect
  // in the cycle after the write, even mid-pass; changing it mid-pass is not supported.
  adc_scan_plan planDec (
    .bufSel (bufSel),
    .multi_channel_mode    (multi_channel_mode),
    .ch     (ch),
    .plan   (plan)
  );

  adc_result_chain #(.RES_W(RES_W)) chain (
    .mclk     (mclk),
    .reset    (reset),
    .ce       (ce),
    .wrEn     (doneAny),
    .chan     (convChannel),
    .bufSel   (bufSel),
    .buffered (plan.buffered),
    .data     (convData),
    .results  (results)
  ); // R06 R07 R13 R14 R20

  assign convStart        = (state == S_ISSUE);
  assign convChannel      = plan.chans[idx];
  assign conversionEndIrq = flag && ie; // R12

  // ==========================================================
  // Decode
  always_comb begin
    wrCsr    = busReq.wr && busReq.addr == CSR_OFF;
    wrCr     = busReq.wr && busReq.addr == CR_OFF;
    rdCsr    = busReq.rd && busReq.addr == CSR_OFF;
    rdLast   = busReq.rd && busReq.addr == (RES_OFF + {1'b0, plan.lastReg, 2'b00});
    trigHit  = (trgSel == TRG_TIMER && timerTrigger) ||
               (trgSel == TRG_EXT && extTrigger);
    doneAny  = state == S_BUSY && convDone;
    doneLast = doneAny && {1'b0, idx} == plan.len - 4'h1;
    passHit  = doneLast && (passCount + 3'h1) == plan.target; // R02 R09 R11
  end

  // ==========================================================
  // Next state
  always_comb begin
    next_state     = state;
    next_flag      = flag;
    next_ie        = ie;
    next_start     = start;
    next_scan      = scan;
    next_autoClr   = autoClr;
    next_armed     = armed;
    next_bufSel    = bufSel;
    next_grp       = multi_channel_mode;
    next_ch        = ch;
    next_trgSel    = trgSel;
    next_idx       = idx;
    next_passCount = passCount;
    unique case (state)
      S_IDLE: begin
        if (start) begin
          next_state = S_ISSUE;
          next_idx   = 3'h0;
        end
      end
      S_ISSUE: next_state = S_BUSY;
      S_BUSY: begin
        if (convDone && !doneLast) begin
          next_idx   = idx + 3'h1;
          next_state = S_ISSUE;
        end else if (doneLast) begin
          next_idx       = 3'h0;
          next_passCount = passHit ? 3'h0 : passCount + 3'h1;
          if (scan) begin
            next_state = (passHit && ie) ? S_PAUSE : S_ISSUE; // R01 R03 R10
          end else if (passHit || !multi_channel_mode) begin
            // Select-single goes to standby after every pass
            next_start = 1'b0; // R10 R11
            next_state = S_IDLE;
          end else begin
            next_state = S_ISSUE;
          end
        end
      end
      S_PAUSE: begin
        if (!flag) begin
          next_state = S_ISSUE; // R04
        end
      end
    endcase
    if (state == S_IDLE && trigHit) begin
      next_start = 1'b1; // R19
    end
    // Flag: software or transfer clear first, hardware set wins
    if (rdCsr && flag) begin
      next_armed = 1'b1;
    end
    if (wrCsr && armed && !busReq.wdata[CSR_FLAG]) begin
      next_flag  = 1'b0; // R05
      next_armed = 1'b0;
    end
    if (autoClr && rdLast) begin
      next_flag  = 1'b0; // R15
      next_armed = 1'b0;
    end
    if (passHit) begin
      next_flag = 1'b1; // R02
    end
    if (wrCsr) begin
      next_ie      = busReq.wdata[CSR_IE];
      next_start   = busReq.wdata[CSR_START];
      next_scan    = busReq.wdata[CSR_SCAN];
      next_autoClr = busReq.wdata[CSR_AUTO];
    end
    if (wrCr) begin
      next_bufSel = busReq.wdata[CR_BUF_LO +: 2];
      next_grp    = busReq.wdata[CR_GRP];
      next_ch     = busReq.wdata[CR_CH_LO +: 3];
      next_trgSel = busReq.wdata[CR_TRG_LO +: 2];
      if (busReq.wdata[CR_BUF_LO +: 2] == BUF_NONE) begin
        next_passCount = 3'h0; // R16 R17
      end
    end
    // Software stop aborts the sequence at once
    if (!next_start && state != S_IDLE) begin
      next_state = S_IDLE; // R01
      next_idx   = 3'h0;
    end
  end

  // ==========================================================
  // Read-back, valid only in the cycle after the strobe
  always_comb begin
    next_readData = 32'h0000_0000;
    if (busReq.rd) begin
      if (busReq.addr == CSR_OFF) begin
        next_readData[CSR_FLAG]  = flag;
        next_readData[CSR_IE]    = ie;
        next_readData[CSR_START] = start;
        next_readData[CSR_SCAN]  = scan;
        next_readData[CSR_AUTO]  = autoClr;
      end else if (busReq.addr == CR_OFF) begin
        next_readData[CR_BUF_LO +: 2] = bufSel;
        next_readData[CR_GRP]         = multi_channel_mode;
        next_readData[CR_CH_LO +: 3]  = ch;
        next_readData[CR_TRG_LO +: 2] = trgSel;
      end else if (busReq.addr[5] && busReq.addr[1:0] == 2'h0) begin
        next_readData[RES_W-1:0] = results[busReq.addr[4:2]];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state     <= S_IDLE;
      flag      <= 1'b0;
      ie        <= 1'b0;
      start     <= 1'b0;
      scan      <= 1'b0;
      autoClr   <= 1'b0;
      armed     <= 1'b0;
      bufSel    <= BUF_NONE;
      multi_channel_mode       <= 1'b0;
      ch        <= 3'h0;
      trgSel    <= TRG_SW;
      idx       <= 3'h0;
      passCount <= 3'h0;
      readData  <= 32'h0000_0000;
    end else if (ce) begin
      state     <= next_state;
      flag      <= next_flag;
      ie        <= next_ie;
      start     <= next_start;
      scan      <= next_scan;
      autoClr   <= next_autoClr;
      armed     <= next_armed;
      bufSel    <= next_bufSel;
      multi_channel_mode       <= next_grp;
      ch        <= next_ch;
      trgSel    <= next_trgSel;
      idx       <= next_idx;
      passCount <= next_passCount;
      readData  <= next_readData;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence s_pass_end;
    ce && passHit && !wrCsr;
  endsequence

  a_scan_keeps_start: assert property (s_pass_end and scan |=> start) // R01
    else $error("start bit dropped in scan mode");
  a_first_pass_flag: assert property (s_pass_end |=> flag) // R02
    else $error("flag not set at end of pass");
  a_pause_on_flag: assert property (s_pass_end and scan && ie |=> state == S_PAUSE) // R03
    else $error("scan did not pause on flag");
  a_resume_on_clear: assert property (ce && state == S_PAUSE && !flag && !wrCsr // R04
      |=> state == S_ISSUE)
    else $error("paused scan did not resume");
  a_clear_after_read: assert property ($fell(flag) |-> $past(armed) || $past(autoClr)) // R05
    else $error("flag cleared without read or transfer");
  a_chain_shift: assert property (ce && doneAny && plan.buffered && bufSel == BUF_1G2 // R06
      && convChannel == 3'h0 |=> results[1] == $past(results[0])
      && results[0] == $past(convData))
    else $error("two-stage chain did not shift");
  a_single_stops: assert property (s_pass_end and !scan |=> !start && state == S_IDLE) // R10
    else $error("single mode did not stop at flag");
  a_irq_follows: assert property (ce && passHit && ie && !wrCsr |=> conversionEndIrq) // R12
    else $error("interrupt request missing");
  a_auto_clear: assert property (ce && autoClr && rdLast && !passHit |=> !flag) // R15
    else $error("final result read did not clear flag");
  a_count_reset: assert property (ce && wrCr && busReq.wdata[1:0] == BUF_NONE // R16
      |=> passCount == 3'h0)
    else $error("buffer count not reset");
  a_trigger_start: assert property (ce && trigHit && state == S_IDLE && !wrCsr // R19
      |=> start)
    else $error("trigger did not set start bit");
endmodule

/* File: rtl/adc_result_chain.sv */
/*
  Eight result registers with the selectable shift chains.
  Assumes one write per cycle at most, qualified by the caller.
*/
`timescale 1ns/1ns
module adc_result_chain #(
  parameter int RES_W = adc_scan_pkg::RES_W
) (
  input  wire logic                   mclk,
  input  wire logic                   reset,
  input  wire logic                   ce,
  input  wire logic                   wrEn,
  input  wire logic [2:0]             chan,
  input  wire logic [1:0]             bufSel,
  input  wire logic                   buffered,
  input  wire logic [RES_W-1:0]       data,
  output logic      [7:0][RES_W-1:0]  results
);
  import adc_scan_pkg::*;

  logic [7:0][RES_W-1:0] next_results;
  logic                  toChain;

  always_comb begin
    next_results = results;
    toChain = buffered && (chan == 3'h0 || (chan == 3'h1 && bufSel == BUF_2G2));
    if (wrEn && toChain) begin
      unique case (bufSel)
        BUF_1G2: begin
          next_results[1] = results[0];
          next_results[0] = data;
        end
        BUF_2G2: begin
          if (chan == 3'h0) begin
            next_results[2] = results[0];
            next_results[0] = data;
          end else begin
            next_results[3] = results[1];
            next_results[1] = data;
          end
        end
        default: begin
          next_results[3] = results[2];
          next_results[2] = results[1];
          next_results[1] = results[0];
          next_results[0] = data;
        end
      endcase
    end else if (wrEn) begin
      next_results[chan] = data;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      results <= {NUM_RES{RES_W'(RES_RESET)}};
    end else if (ce) begin
      results <= next_results;
    end
  end
endmodule

/* File: rtl/adc_scan_pkg.sv */
/*
  Shared constants and carriers for the group-scan buffer sequencer.
  Assumes a 32-bit register port with byte addresses and a 10-bit converter core.
*/
package adc_scan_pkg;
  // ==========================================================
  // Widths
  localparam int          ADDR_W     = 6;
  localparam int          RES_W      = 10;
  localparam int          NUM_RES    = 8;
  // ==========================================================
  // Register offsets
  localparam logic [5:0]  CSR_OFF    = 6'h00;
  localparam logic [5:0]  CR_OFF     = 6'h04;
  localparam logic [5:0]  RES_OFF    = 6'h20;
  // ==========================================================
  // Status/control field positions
  localparam int          CSR_FLAG   = 7;
  localparam int          CSR_IE     = 6;
  localparam int          CSR_START  = 5;
  localparam int          CSR_SCAN   = 4;
  localparam int          CSR_AUTO   = 3;
  // Control field positions
  localparam int          CR_BUF_LO  = 0;
  localparam int          CR_GRP     = 2;
  localparam int          CR_CH_LO   = 4;
  localparam int          CR_TRG_LO  = 8;
  // ==========================================================
  // Reset values and encodings
  localparam logic [RES_W-1:0] RES_RESET = 10'h000;
  localparam logic [1:0]  BUF_NONE   = 2'h0;
  localparam logic [1:0]  BUF_1G2    = 2'h1;
  localparam logic [1:0]  BUF_2G2    = 2'h2;
  localparam logic [1:0]  BUF_1G4    = 2'h3;
  localparam logic [1:0]  TRG_SW     = 2'h0;
  localparam logic [1:0]  TRG_TIMER  = 2'h1;
  localparam logic [1:0]  TRG_EXT    = 2'h3;
  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
    logic              wr;
    logic              rd;
  } bus_req_t;

  typedef struct packed {
    logic [3:0]      len;
    logic [2:0]      target;
    logic [2:0]      lastReg;
    logic            buffered;
    logic [7:0][2:0] chans;
  } plan_t;

  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_ISSUE = 2'b01,
    S_BUSY  = 2'b11,
    S_PAUSE = 2'b10
  } seq_state_t;
endpackage

/* File: rtl/adc_scan_plan.sv */
/*
  Decodes buffer select, group mode and channel select into one scan pass.
  Assumes the configuration is stable while a pass runs.
*/
`timescale 1ns/1ns
module adc_scan_plan (
  input  wire logic [1:0]          bufSel,
  input  wire logic                multi_channel_mode,
  input  wire logic [2:0]          ch,
  output adc_scan_pkg::plan_t      plan
);
  import adc_scan_pkg::*;

  logic       bufOnly;
  logic       combined;
  logic [3:0] nBuf;
  logic [3:0] extStart;
  logic [3:0] extEnd;

  always_comb begin
    bufOnly  = (bufSel == BUF_1G2 && ch[2:1] == 2'h0) ||
               (bufSel == BUF_2G2 && !ch[2] && !ch[0]) ||
               (bufSel == BUF_1G4 && !ch[2]);
    combined = multi_channel_mode && ((bufSel == BUF_1G2 && ch[2:1] != 2'h0) ||
               (bufSel != BUF_NONE && bufSel != BUF_1G2 && ch[2]));
    nBuf     = (bufSel == BUF_2G2) ? 4'h2 : 4'h1;
    extStart = (bufSel == BUF_1G2) ? 4'h2 : 4'h4;
    extEnd   = ch[2] ? (4'h4 + {2'h0, ch[1:0]}) : (4'h2 + {3'h0, ch[0]});
    plan     = '0;
    for (int i = 0; i < NUM_RES; i++) begin
      plan.chans[i] = 3'(i);
    end
    plan.target = 3'h1;
    if (bufOnly) begin // R09
      plan.buffered = 1'b1;
      plan.len      = nBuf;
      unique case (bufSel)
        BUF_1G2: begin
          plan.target  = {2'h0, ch[0]} + 3'h1;
          plan.lastReg = {2'h0, ch[0]};
        end
        BUF_2G2: begin
          plan.target  = {2'h0, ch[1]} + 3'h1;
          plan.lastReg = ch[1] ? 3'h3 : 3'h1;
        end
        default: begin
          plan.target  = {1'b0, ch[1:0]} + 3'h1;
          plan.lastReg = {1'b0, ch[1:0]};
        end
      endcase
    end else if (combined) begin // R13 R14
      // Buffered inputs first, then the appended inputs in order
      plan.buffered = 1'b1;
      plan.len      = nBuf + extEnd - extStart + 4'h1;
      plan.lastReg  = extEnd[2:0];
      for (int i = 0; i < NUM_RES; i++) begin
        if (4'(i) >= nBuf) begin
          plan.chans[i] = 3'(4'(i) - nBuf + extStart);
        end
      end
    end else if (multi_channel_mode) begin // R20
      // Unavailable combinations fall back to plain group conversion
      plan.len      = {1'b0, ch} + 4'h1;
      plan.lastReg  = ch;
    end else begin
      plan.len      = 4'h1;
      plan.chans[0] = ch;
      plan.lastReg  = ch;
    end
  end
endmodule

/* File: verif/adc_core_model.sv */
/*
  Behavioural converter core facing the sequencer's converter link.
  Assumes one-cycle start pulses; a new start abandons any conversion in flight.
*/
`timescale 1ns/1ns
module adc_core_model (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       slow,
  input  wire logic       convStart,
  input  wire logic [2:0] convChannel,
  output logic            convDone,
  output logic [9:0]      convData,
  output logic [6:0]      seq
);
  logic [2:0] ch;
  logic [4:0] cnt;
  logic       busy;
  // ==========
  // Conversion
  // Idle data toggles so a stale result never passes for a fresh one
  always_ff @(posedge mclk) begin
    convDone <= 1'b0;
    convData <= ~convData;
    if (reset) begin
      busy     <= 1'b0;
      seq      <= 7'h00;
      convData <= 10'h000;
    end else if (convStart) begin
      busy <= 1'b1;
      ch   <= convChannel;
      cnt  <= slow ? 5'h13 : 5'h00;
    end else if (busy && cnt == 5'h00) begin
      busy     <= 1'b0;
      convDone <= 1'b1;
      convData <= {ch, seq};
      seq      <= seq + 7'h01;
    end else if (busy) begin
      cnt <= cnt - 5'h01;
    end
  end
endmodule

/* File: verif/adc_group_scan_buffer_sequencer_tb_top.sv */
/*
  Self-checking bench for the group-scan buffer sequencer.
  Assumes the behavioural converter model; results carry channel and count.
*/
`timescale 1ns/1ns
module adc_group_scan_buffer_sequencer_tb_top;
  import adc_scan_pkg::*;
  localparam int LIMIT = 40000;
  logic             mclk;
  logic             reset;
  logic             ce;
  logic             timerTrigger;
  logic             extTrigger;
  logic             slow;
  bus_req_t         busReq;
  logic [31:0]      readData;
  logic [31:0]      rdata;
  logic             convStart;
  logic [2:0]       convChannel;
  logic             convDone;
  logic [RES_W-1:0] convData;
  logic             conversionEndIrq;
  logic [6:0]       seq;
  int               errCount;
  int               cmpCount;
  int               nStart;
  int               cyc;
  int               b;
  int               pb;
  int               n0;

  adc_group_scan_buffer_sequencer i_dut (
    .mclk(mclk), .reset(reset), .ce(ce), .busReq(busReq), .readData(readData),
    .timerTrigger(timerTrigger), .extTrigger(extTrigger), .convStart(convStart),
    .convChannel(convChannel), .convDone(convDone), .convData(convData),
    .conversionEndIrq(conversionEndIrq)
  );
  adc_core_model i_model (
    .mclk(mclk), .reset(reset), .slow(slow), .convStart(convStart),
    .convChannel(convChannel), .convDone(convDone), .convData(convData), .seq(seq)
  );

  // ==========
  // Clock, start counter and hang guard
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (convStart === 1'b1) nStart++;
    if (cyc == LIMIT) begin
      errCount++;
      finishTest();
    end
  end

  // ==========
  // Helpers
  function automatic logic [31:0] rv(input int c, input int n);
    rv = {22'h0, c[2:0], n[6:0]};
  endfunction
  function automatic logic [31:0] cr(input logic [1:0] bs, input logic g, input logic [2:0] ch);
    cr = {22'h0, TRG_SW, 1'b0, ch, 1'b0, g, bs};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      errCount++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge mclk);
    busReq <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk);
    busReq <= '{a, d, 1'b0, 1'b0};
  endtask
  task automatic rd(input logic [5:0] a);
    @(posedge mclk);
    busReq <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge mclk);
    busReq <= '{a, 32'h0, 1'b0, 1'b0};
    #1 rdata = readData;
  endtask
  task automatic rdc(input logic [5:0] a, input logic [31:0] e);
    rd(a);
    chk(rdata, e);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic tend(input string s);
    $display("test %s done", s);
  endtask
  // Polling reads also arm the flag clear, as software would
  task automatic waitCsr(input int pos, input logic v);
    for (int i = 0; i < 400; i++) begin
      rd(CSR_OFF);
      if (rdata[pos] === v) break;
    end
    chk(32'(rdata[pos]), 32'(v));
  endtask
  task automatic waitIrq;
    for (int i = 0; i < 800 && conversionEndIrq !== 1'b1; i++) @(posedge mclk);
    #1 chk(32'(conversionEndIrq), 32'h1);
  endtask
  task automatic bufRun(input logic [1:0] bs, input logic [2:0] ch, input int n,
                        input logic [31:0] csr);
    wr(CR_OFF, 32'h0);
    wr(CR_OFF, cr(bs, 1'b1, ch));
    b = int'(seq);
    n0 = nStart;
    wr(CSR_OFF, csr);
    if (csr[CSR_IE]) waitIrq();
    else waitCsr(CSR_FLAG, 1'b1);
    chk(32'(nStart - n0), 32'(n));
  endtask
  task automatic selRun(input logic [31:0] e);
    wr(CSR_OFF, 32'h20);
    waitCsr(CSR_START, 1'b0);
    rdc(CSR_OFF, e);
  endtask
  task automatic finishTest;
    $display("comparisons %0d mismatches %0d", cmpCount, errCount);
    if (errCount == 0 && cmpCount > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ==========
  // Tests
  initial begin
    reset = 1'b1;
    ce = 1'b1;
    timerTrigger = 1'b0;
    extTrigger = 1'b0;
    slow = 1'b0;
    busReq = '0;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    rdc(CSR_OFF, 32'h0);
    rdc(CR_OFF, 32'h0);
    rdc(RES_OFF, 32'h0);
    rdc(6'h10, 32'h0);
    // Frozen by the clock enable: the start write must be lost
    ce <= 1'b0;
    wr(CSR_OFF, 32'h20);
    ce <= 1'b1;
    rdc(CSR_OFF, 32'h0);
    tend("reset");
    // Scan with interrupt: pause, refused clear, then resume
    wr(CR_OFF, cr(2'h0, 1'b1, 3'h3));
    b = int'(seq);
    n0 = nStart;
    wr(CSR_OFF, 32'h70);
    waitIrq();
    chk(32'(nStart - n0), 32'h4);
    n0 = nStart;
    idle(30);
    chk(32'(nStart - n0), 32'h0);
    wr(CSR_OFF, 32'h70);
    #1 chk(32'(conversionEndIrq), 32'h1);
    rdc(CSR_OFF, 32'hf0);
    rdc(RES_OFF + 6'h0c, rv(3, b + 3));
    wr(CSR_OFF, 32'h70);
    n0 = nStart;
    idle(30);
    chk(32'(nStart > n0), 32'h1);
    wr(CSR_OFF, 32'h0);
    idle(40);
    rd(CSR_OFF);
    wr(CSR_OFF, 32'h0);
    tend("scan_pause");
    // Buffer-only chains and flag points
    bufRun(2'h1, 3'h1, 2, 32'h20);
    rdc(RES_OFF, rv(0, b + 1));
    rdc(RES_OFF + 6'h04, rv(0, b));
    bufRun(2'h2, 3'h2, 4, 32'h20);
    rdc(RES_OFF, rv(0, b + 2));
    rdc(RES_OFF + 6'h04, rv(1, b + 3));
    rdc(RES_OFF + 6'h08, rv(0, b));
    rdc(RES_OFF + 6'h0c, rv(1, b + 1));
    bufRun(2'h3, 3'h0, 1, 32'h20);
    bufRun(2'h3, 3'h3, 4, 32'h20);
    for (int k = 0; k < 4; k++) rdc(RES_OFF + 6'(4 * k), rv(0, b + 3 - k));
    tend("buffer_only");
    // Group plus buffer, automatic clear on final register
    pb = b;
    bufRun(2'h3, 3'h6, 4, 32'h68);
    rdc(RES_OFF, rv(0, b));
    for (int k = 1; k < 4; k++) rdc(RES_OFF + 6'(4 * k), rv(0, pb + 4 - k));
    rdc(RES_OFF + 6'h10, rv(4, b + 1));
    rdc(RES_OFF + 6'h14, rv(5, b + 2));
    chk(32'(conversionEndIrq), 32'h1);
    rdc(RES_OFF + 6'h18, rv(6, b + 3));
    rdc(CSR_OFF, 32'h48);
    chk(32'(conversionEndIrq), 32'h0);
    bufRun(2'h1, 3'h3, 3, 32'h20);
    rdc(RES_OFF + 6'h0c, rv(3, b + 2));
    bufRun(2'h2, 3'h4, 3, 32'h20);
    rdc(RES_OFF + 6'h10, rv(4, b + 2));
    tend("group_buffer");
    // Buffered scan keeps converting past the flag
    wr(CR_OFF, 32'h0);
    wr(CR_OFF, cr(2'h1, 1'b1, 3'h1));
    slow <= 1'b1;
    wr(CSR_OFF, 32'h30);
    waitCsr(CSR_FLAG, 1'b1);
    n0 = nStart;
    idle(60);
    chk(32'(nStart > n0), 32'h1);
    rdc(CSR_OFF, 32'hb0);
    wr(CSR_OFF, 32'h0);
    idle(30);
    // A pass may end beside the stop write, so arm and clear once more
    rd(CSR_OFF);
    wr(CSR_OFF, 32'h0);
    slow <= 1'b0;
    tend("buffer_scan");
    // Select-single buffering: count across starts and count reset
    wr(CR_OFF, 32'h0);
    wr(CR_OFF, cr(2'h1, 1'b0, 3'h1));
    selRun(32'h0);
    wr(CR_OFF, 32'h0);
    wr(CR_OFF, cr(2'h1, 1'b0, 3'h1));
    selRun(32'h0);
    selRun(32'h80);
    rdc(RES_OFF, rv(0, int'(seq) - 1));
    wr(CSR_OFF, 32'h0);
    tend("select_single");
    // Timer and external start
    slow <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      wr(CR_OFF, {22'h0, (i == 0) ? TRG_TIMER : TRG_EXT, 8'h00});
      n0 = nStart;
      @(posedge mclk);
      timerTrigger <= (i == 0);
      extTrigger <= (i == 1);
      @(posedge mclk);
      timerTrigger <= 1'b0;
      extTrigger <= 1'b0;
      rdc(CSR_OFF, 32'h20);
      waitCsr(CSR_FLAG, 1'b1);
      chk(32'(nStart - n0), 32'h1);
      wr(CSR_OFF, 32'h0);
    end
    tend("triggers");
    finishTest();
  end
endmodule
